// ==== core/slog_guard.sv ====
`timescale 1ns/100ps
module slog_guard (
	input  wire logic clk_sys,
	input  wire logic rst,
	// switching-cycle and comparator pins, all asynchronous
	input  wire logic cycle_start,
	input  wire logic secondary_overcurrent_threshold,
	// supply monitor levels, asynchronous
	input  wire logic supply_undervoltage_threshold,
	input  wire logic supply_restart_level,
	input  wire logic supply_turn_on_level,
	// power stage control and status, all from flip-flops
	output logic      switch_enable,
	output logic      startup_charge_current,
	output logic      fault_latched,
	output logic      warning
);
	// ***************************************************************
	// input synchronisers
	// ***************************************************************
	logic cyc_s;
	logic ocp_s;
	logic uvlo_s;
	logic rst_lvl_s;
	logic on_lvl_s;

	// each pin moves on its own analog timing, hence two flops apiece
	slog_sync u_cyc (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (cycle_start),
		.dout    (cyc_s)
	);

	slog_sync u_ocp (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (secondary_overcurrent_threshold),
		.dout    (ocp_s)
	);

	slog_sync u_uvlo (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (supply_undervoltage_threshold),
		.dout    (uvlo_s)
	);

	slog_sync u_rlvl (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (supply_restart_level),
		.dout    (rst_lvl_s)
	);

	slog_sync u_olvl (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     (supply_turn_on_level),
		.dout    (on_lvl_s)
	);

	// ***************************************************************
	// state
	// ***************************************************************
	// cycle history and the protection sequence in one register
	typedef struct packed {
		slog_pkg::slog_state_e state;
		logic                  cyc_d;
		logic                  trip_seen;
		logic [1:0]            trip_run;
		logic                  sw_en;
		logic                  chg_en;
		logic                  fault;
		logic                  warn;
	} slog_regs_s;

	slog_regs_s r;
	slog_regs_s next_r;

	// ***************************************************************
	// cycle boundary and trip qualification
	// ***************************************************************
	logic boundary;
	logic trip_cycle;
	logic clean_cycle;

	// one clock wide, so each switching cycle is judged exactly once
	assign boundary    = cyc_s & ~r.cyc_d;
	assign trip_cycle  = boundary & r.trip_seen;
	assign clean_cycle = boundary & ~r.trip_seen;

	// ***************************************************************
	// protection sequencer
	// ***************************************************************
	always_comb begin
		next_r       = r;
		next_r.cyc_d = cyc_s;
		// any trip inside the current cycle counts for that cycle
		if (ocp_s) begin
			next_r.trip_seen = 1'b1;
		end
		// the sample at the boundary opens the next cycle's history
		if (boundary) begin
			next_r.trip_seen = ocp_s;
		end
		unique case (r.state)
			slog_pkg::SLOG_IDLE: begin
				// a single trip only warns; a glitch must not shut down
				if (trip_cycle) begin
					next_r.state    = slog_pkg::SLOG_WARN;
					next_r.trip_run = 2'h1;
				end
			end
			slog_pkg::SLOG_WARN: begin
				if (trip_cycle) begin
					next_r.trip_run = r.trip_run + 2'h1;
					// tripped cycles back to back make a real fault
					if (next_r.trip_run == 2'(slog_pkg::SLOG_TRIP_COUNT)) begin
						next_r.state = slog_pkg::SLOG_LATCHED;
					end
				end else if (clean_cycle) begin
					next_r.state    = slog_pkg::SLOG_IDLE;
					next_r.trip_run = 2'h0;
				end
			end
			slog_pkg::SLOG_LATCHED: begin
				// trips are ignored here; only undervoltage releases
				if (uvlo_s) begin
					next_r.state = slog_pkg::SLOG_DISCHG;
				end
			end
			slog_pkg::SLOG_DISCHG: begin
				// charger stays off so the supply can sag to restart level
				if (rst_lvl_s) begin
					next_r.state = slog_pkg::SLOG_RECHARGE;
				end
			end
			slog_pkg::SLOG_RECHARGE: begin
				if (on_lvl_s) begin
					// back to idle; a persisting fault trips again
					next_r.state     = slog_pkg::SLOG_IDLE;
					next_r.trip_seen = 1'b0;
					next_r.trip_run  = 2'h0;
				end
			end
			default: begin
				// unreachable code: fall to the safe, switched-off state
				next_r.state = slog_pkg::SLOG_LATCHED;
			end
		endcase
		// outputs follow the next state so they switch together with it
		next_r.sw_en  = 1'b0;
		next_r.chg_en = 1'b0;
		next_r.fault  = 1'b0;
		next_r.warn   = 1'b0;
		unique case (next_r.state)
			slog_pkg::SLOG_IDLE: begin
				next_r.sw_en = 1'b1;
			end
			slog_pkg::SLOG_WARN: begin
				// keep switching while the event is judged
				next_r.sw_en = 1'b1;
				next_r.warn  = 1'b1;
			end
			slog_pkg::SLOG_LATCHED: begin
				// switch already held off by the default above
				next_r.fault = 1'b1;
			end
			slog_pkg::SLOG_DISCHG: begin
				// no switching, no charging: the supply capacitor sags
				next_r.chg_en = 1'b0;
			end
			slog_pkg::SLOG_RECHARGE: begin
				// recharge spans restart level up to turn-on level
				next_r.chg_en = 1'b1;
			end
			default: begin
				next_r.fault = 1'b1;
			end
		endcase
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	// switch allowed out of reset: reset is the undervoltage restart itself
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r.state     <= slog_pkg::SLOG_RESET_STATE;
			r.cyc_d     <= 1'b0;
			r.trip_seen <= 1'b0;
			r.trip_run  <= 2'h0;
			r.sw_en     <= 1'b1;
			r.chg_en    <= 1'b0;
			r.fault     <= 1'b0;
			r.warn      <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	// all four straight from flip-flops, so none glitches on a state change
	assign switch_enable          = r.sw_en;
	assign startup_charge_current = r.chg_en;
	assign fault_latched          = r.fault;
	assign warning                = r.warn;
endmodule

// ==== core/slog_pkg.sv ====
package slog_pkg;
	// ***************************************************************
	// protection states
	// ***************************************************************
	typedef enum logic [2:0] {
		SLOG_IDLE     = 3'h0,
		SLOG_WARN     = 3'h1,
		SLOG_LATCHED  = 3'h3,
		SLOG_DISCHG   = 3'h2,
		SLOG_RECHARGE = 3'h6
	} slog_state_e;

	localparam slog_state_e SLOG_RESET_STATE = SLOG_IDLE;
	localparam int          SLOG_TRIP_COUNT  = 2;
	// typical supply levels in millivolts, for reference by the bench
	localparam int          SLOG_RESTART_MV  = 4500;
	localparam int          SLOG_TURN_ON_MV  = 14000;
	localparam int          SLOG_SYNC_STAGES = 2;
endpackage

// ==== core/slog_sync.sv ====
`timescale 1ns/100ps
module slog_sync (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic [slog_pkg::SLOG_SYNC_STAGES-1:0] stage;
	} slog_sync_s;

	slog_sync_s r;
	slog_sync_s next_r;

	// first stage is read only by the second
	always_comb begin
		next_r       = r;
		next_r.stage = {r.stage[slog_pkg::SLOG_SYNC_STAGES-2:0], din};
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign dout = r.stage[slog_pkg::SLOG_SYNC_STAGES-1];
endmodule

// ==== dv/slog_guard_props.sv ====
`timescale 1ns/100ps
module slog_guard_props (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cycle_start,
	input wire logic supply_undervoltage_threshold,
	input wire logic supply_restart_level,
	input wire logic supply_turn_on_level,
	input wire logic switch_enable,
	input wire logic startup_charge_current,
	input wire logic fault_latched,
	input wire logic warning
);
	// ***
	// checks
	// ***
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_shut;
		!switch_enable && !startup_charge_current;
	endsequence
	property p_off; fault_latched |-> s_shut; endproperty
	a_off: assert property (p_off) else $error("switching while latched");
	property p_two; $rose(fault_latched) |-> $past(warning); endproperty
	a_two: assert property (p_two) else $error("latch without warning");
	property p_clr; $fell(fault_latched) |-> $past(supply_undervoltage_threshold, 2); endproperty
	a_clr: assert property (p_clr) else $error("latch cleared early");
	property p_chg; $rose(startup_charge_current) |-> $past(supply_restart_level, 2); endproperty
	a_chg: assert property (p_chg) else $error("charger on early");
	property p_run; $rose(switch_enable) |-> $past(supply_turn_on_level, 2); endproperty
	a_run: assert property (p_run) else $error("resumed early");
	property p_wrn; warning |-> switch_enable && !fault_latched; endproperty
	a_wrn: assert property (p_wrn) else $error("warning shut down");
	property p_cut; startup_charge_current |-> !switch_enable; endproperty
	a_cut: assert property (p_cut) else $error("charging while on");
	property p_bnd; $rose(warning) |-> $past(cycle_start, 2); endproperty
	a_bnd: assert property (p_bnd) else $error("warning off boundary");
endmodule

// ==== dv/slog_supply.sv ====
`timescale 1ns/100ps
module slog_supply (
	input  wire logic clk_sys,
	input  wire logic sw,
	input  wire logic chg,
	output logic      uv,
	output logic      low,
	output logic      on
);
	// ***
	// supply capacitor model, millivolts
	// ***
	localparam int UV_MV = 9000;
	int mv = 15000;
	always @(posedge clk_sys) begin
		if (chg)
			mv <= mv + 500;
		else if (!sw && mv > 0)
			mv <= mv - 500;
	end
	assign uv  = mv < UV_MV;
	assign low = mv < slog_pkg::SLOG_RESTART_MV;
	assign on  = mv >= slog_pkg::SLOG_TURN_ON_MV;
endmodule

// ==== dv/tb_slog_guard.sv ====
`timescale 1ns/100ps
module tb_slog_guard;
	// ***
	// bench
	// ***
	logic       clk_sys = 0, rst = 1, cs = 0, oc = 0, w = 0, t;
	logic       uv, low, on, sw, chg, fl, wn, sc;
	logic [1:0] e;
	logic [5:0] pat = 6'h3D;
	int         fail_count = 0, cmp_count = 0;
	always #5 clk_sys = ~clk_sys;
	slog_guard i_dut (.clk_sys(clk_sys), .rst(rst), .cycle_start(cs),
		.secondary_overcurrent_threshold(oc), .supply_undervoltage_threshold(uv),
		.supply_restart_level(low), .supply_turn_on_level(on), .switch_enable(sw),
		.startup_charge_current(chg), .fault_latched(fl), .warning(wn));
	slog_supply i_sup (.clk_sys(clk_sys), .sw(sw), .chg(chg), .uv(uv), .low(low), .on(on));
	function automatic logic [1:0] exp_f(logic wa, logic tr);
		return {tr & wa, tr & ~wa};
	endfunction
	task tick(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task chk(logic [1:0] g, logic [1:0] x);
		cmp_count++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value at %0t: %h %h", $time, g, x);
		end
	endtask
	task conclude;
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#100000;
		fail_count++;
		conclude;
	end
	initial begin
		void'($urandom(23));
		tick(3);
		rst = 0;
		for (int i = 0; i < 40; i++) begin
			t = i < 6 ? pat[i] : 1'($urandom);
			cs = 0;
			oc = t;
			tick(3);
			// trip stays latched in the cycle though the comparator drops
			oc = 0;
			tick(3);
			cs = 1;
			tick(6);
			e = exp_f(w, t);
			chk({fl, wn}, e);
			w = e[0];
			if (e[1]) begin
				chk({fl, sw}, 2'h2);
				sc = 1'b0;
				for (int k = 0; k < 300 && sw !== 1'b1; k++) begin
					sc = sc | chg;
					tick(1);
				end
				chk({fl, sw}, 2'h1);
				chk({sc, chg}, 2'h2);
			end
		end
		conclude;
	end
endmodule
bind slog_guard slog_guard_props i_props (.*);
